/* logic/serial_flash_frontend.sv */
// Function
// R1: extended, dual and quad protocols, same functions
// R2: config register bits select the protocol
// R3: everything shifted most significant bit first
// R4: sample from first rising clock after select
// R5: instruction lanes follow the protocol width
// R6: multi-lane protocols carry every phase in parallel
// R7: standard frame opens with one instruction byte
// R8: execute-in-place takes address, dummies, then data
// R9: extended instruction on lane zero, data varies
// R10: read instructions end in a data-out phase
// R11: host may deselect after any output bit
// R12: write-type frames must end on byte boundary; code requires a multiple of 8 clocks in every protocol
// R13: array access ignored during internal cycles
// R14: internal cycles undisturbed except by suspend
// R15: suspend pauses program/erase, not otp/chip/nvcfg
// R16: resume restarts the suspended cycle
// R17: status polls accepted during internal cycles
// R18: polls never disturb the internal cycle
// R19: 64-byte one-time-programmable area
// R20: 24-bit addresses, 4K subsectors, 64K sectors
`timescale 1ns/10ps
`default_nettype none
module serial_flash_frontend import sf_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic [3:0] i_lane_in,
    output logic [3:0] o_lane_out,
    output logic [3:0] o_lane_oe,
    output logic o_rd_req,
    output logic [23:0] o_rd_addr,
    input wire logic i_rd_valid,
    output logic o_rd_ready,
    input wire logic [7:0] i_rd_data,
    output logic o_wr_valid,
    output logic [7:0] o_wr_data,
    output logic o_op_start,
    output logic [2:0] o_op_kind,
    output logic [23:0] o_op_addr,
    input wire logic i_op_done,
    output logic o_suspend,
    output logic o_resume,
    output logic o_busy
);
    logic cs_n_r, sclk_r;
    st_t st_r, st_nxt;
    logic [7:0] sh_r, cmd_r, data_r, cur_r, vcr_r, vecr_r, nvcr_r, sr_r;
    logic [23:0] addr_r, op_addr_r;
    logic [2:0] bit_r, obit_r, clk_cnt_r;
    logic [1:0] abyte_r;
    logic [3:0] dcnt_r, lane_out_r, lane_oe_r;
    logic [5:0] otp_ptr_r;
    logic wel_r, busy_r, susp_r, rej_r, exit_r;
    op_kind_t kind_r, kind_nxt;
    logic rd_req_r, wr_valid_r, op_start_r, suspend_r, resume_r;
    logic [7:0] status_b, flag_b, src_b, nb;
    logic [7:0] fifo_data, otp_rdata;
    logic fifo_valid;

    // pin edges, inputs are synchronous to i_mclk
    wire sel = !i_cs_n;
    wire cs_fall = !i_cs_n && cs_n_r;
    wire cs_rise = i_cs_n && !cs_n_r;
    wire sck_rise = sel && i_sclk && !sclk_r; // R4
    wire sck_fall = sel && !i_sclk && sclk_r;

    // protocol and lane width
    wire [1:0] proto = vecr_r[PROTO_LSB +: 2]; // R2
    wire eip = vecr_r[EXEC_IN_PLACE_BIT];
    wire is_quad = proto == QUAD_LANE_PROTOCOL;
    wire is_dual = proto == DUAL_LANE_PROTOCOL;
    wire ext = !is_quad && !is_dual; // R1
    wire [3:0] pw = is_quad ? 4'h4 : is_dual ? 4'h2 : 4'h1; // R5 R6
    wire [3:0] dout_w = (ext && cmd_r == QUAD_OUT_READ_CMD) ? 4'h4 : pw; // R9
    wire [3:0] lw = (st_r == ST_DOUT) ? dout_w : pw;
    wire [7:0] in_byte = (lw == 4'h4) ? {sh_r[3:0], i_lane_in} :
        (lw == 4'h2) ? {sh_r[5:0], i_lane_in[1], i_lane_in[0]} :
        {sh_r[6:0], i_lane_in[0]}; // R3 R9
    wire byte_done = sck_rise && (({1'b0, bit_r} + lw) == 4'h8);

    // instruction classes
    wire is_arr_rd = cmd_r == ARRAY_READ_CMD || cmd_r == FAST_READ_CMD || cmd_r == QUAD_OUT_READ_CMD;
    wire is_otp_rd = cmd_r == OTP_READ_CMD;
    wire is_poll = cmd_r == STATUS_READ_CMD || cmd_r == FLAG_STATUS_READ_CMD;
    wire is_pp = cmd_r == PAGE_PROGRAM_CMD;
    wire is_otp_wr = cmd_r == OTP_PROGRAM_CMD;
    wire is_sse = cmd_r == SUBSECTOR_ERASE_CMD;
    wire is_se = cmd_r == SECTOR_ERASE_CMD;
    wire is_chip = cmd_r == WHOLE_CHIP_ERASE_CMD;
    wire is_srw = cmd_r == STATUS_WRITE_CMD;
    wire is_nvw = cmd_r == NONVOLATILE_CONFIG_WRITE_CMD;
    wire is_susp = cmd_r == SUSPEND_PROGRAM_ERASE_CMD;
    wire is_res = cmd_r == RESUME_PROGRAM_ERASE_CMD;
    wire is_modify = is_pp || is_otp_wr || is_sse || is_se || is_chip || is_srw || is_nvw;
    wire has_addr = is_arr_rd || is_otp_rd || is_pp || is_otp_wr || is_sse || is_se;
    wire needs_dummy = cmd_r == FAST_READ_CMD || cmd_r == QUAD_OUT_READ_CMD || is_otp_rd;
    wire bound_type = is_modify || cmd_r == WRITE_ENABLE_CMD || cmd_r == WRITE_DISABLE_CMD ||
        cmd_r == FLAG_CLEAR_CMD || cmd_r == VOLATILE_CONFIG_WRITE_CMD || cmd_r == ENHANCED_CONFIG_WRITE_CMD;
    // while busy only polls and suspend get through; nothing modifies while suspended
    wire blocked = (busy_r && !is_poll && !is_susp) || (susp_r && is_modify); // R13 R14 R17
    wire can_susp = kind_r == OPK_PAGE || kind_r == OPK_SUBSECTOR || kind_r == OPK_SECTOR; // R15

    wire st_t dec_st = blocked ? ST_IGN : has_addr ? ST_ADDR : is_poll ? ST_DOUT : ST_DIN; // R7 R10
    wire st_t addr_st = (busy_r && is_arr_rd) ? ST_IGN : needs_dummy ? ST_DUMMY :
        (is_arr_rd || is_otp_rd) ? ST_DOUT : ST_DIN; // R13 R10
    wire [3:0] dummy_ld = vcr_r[DUMMY_LSB +: 4] - 4'h1;

    // frame completion
    wire fin = cs_rise && st_r == ST_DIN;
    wire aligned = clk_cnt_r == 3'h0;
    wire exec = fin && (aligned || !bound_type); // R12
    wire rej_set = fin && bound_type && !aligned; // R12
    wire start_op = exec && wel_r && is_modify;
    // a cycle that finishes as suspend lands is done, not suspended
    wire do_susp = exec && is_susp && busy_r && can_susp && !i_op_done; // R15 R14
    wire do_res = exec && is_res && susp_r; // R16

    assign kind_nxt = is_pp ? OPK_PAGE : is_sse ? OPK_SUBSECTOR : is_se ? OPK_SECTOR :
        is_chip ? OPK_CHIP : is_otp_wr ? OPK_OTP : is_srw ? OPK_STATUS : OPK_NVCFG;
    wire [23:0] op_addr_nxt = is_sse ? (addr_r & SUBSECTOR_MASK) :
        is_se ? (addr_r & SECTOR_MASK) : addr_r; // R20

    // output data path
    wire pop = sck_fall && st_r == ST_DOUT && obit_r == 3'h0 && is_arr_rd;
    wire otp_we = byte_done && st_r == ST_DIN && is_otp_wr && wel_r; // R19
    wire otp_adv = otp_we || (sck_fall && st_r == ST_DOUT && obit_r == 3'h0 && is_otp_rd);
    always_comb begin
        status_b = sr_r;
        status_b[SR_BUSY] = busy_r;
        status_b[SR_WEL] = wel_r;
        flag_b = 8'h00;
        flag_b[FS_READY] = !busy_r;
        flag_b[FS_REJECTED] = rej_r;
        flag_b[FS_SUSPENDED] = susp_r;
    end
    assign src_b = cmd_r == STATUS_READ_CMD ? status_b : cmd_r == FLAG_STATUS_READ_CMD ? flag_b :
        is_otp_rd ? otp_rdata : fifo_valid ? fifo_data : 8'hFF; // R17 R18
    assign nb = (obit_r == 3'h0) ? src_b : 8'(cur_r << lw); // R3
    wire [3:0] lane_nxt = (lw == 4'h4) ? nb[7:4] : (lw == 4'h2) ? {2'b00, nb[7], nb[6]} :
        {2'b00, nb[7], 1'b0};
    wire [3:0] oe_nxt = (lw == 4'h4) ? 4'hF : (lw == 4'h2) ? 4'h3 : 4'h2;

    always_comb begin
        st_nxt = st_r;
        if (cs_rise) begin
            st_nxt = ST_IDLE;
        end else if (cs_fall) begin
            st_nxt = eip ? ST_ADDR : ST_CMD; // R7 R8
        end else if (st_r == ST_DEC) begin
            st_nxt = dec_st;
        end else if (byte_done && st_r == ST_CMD) begin
            st_nxt = ST_DEC;
        end else if (byte_done && st_r == ST_ADDR && abyte_r == LAST_ADDR_BYTE) begin
            st_nxt = addr_st;
        end else if (sck_rise && st_r == ST_DUMMY && dcnt_r == 4'h0) begin
            st_nxt = ST_DOUT; // R8
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cs_n_r <= 1'b1;
            sclk_r <= 1'b0;
            st_r <= ST_IDLE;
        end else begin
            cs_n_r <= i_cs_n;
            sclk_r <= i_sclk;
            st_r <= st_nxt;
        end
    end

    // input shifting and counters
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sh_r <= 8'h00;
            bit_r <= 3'h0;
            clk_cnt_r <= 3'h0;
            abyte_r <= 2'h0;
            dcnt_r <= 4'h0;
        end else if (cs_fall) begin
            bit_r <= 3'h0;
            clk_cnt_r <= 3'h0;
            abyte_r <= 2'h0;
        end else if (sck_rise) begin
            sh_r <= in_byte; // R4
            bit_r <= 3'(bit_r + lw[2:0]);
            clk_cnt_r <= clk_cnt_r + 3'h1; // R12
            if (byte_done && st_r == ST_ADDR) begin
                abyte_r <= abyte_r + 2'h1;
            end
            dcnt_r <= (st_r == ST_DUMMY) ? dcnt_r - 4'h1 : dummy_ld;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cmd_r <= 8'h00;
            addr_r <= 24'h000000;
            data_r <= 8'h00;
            otp_ptr_r <= 6'h00;
        end else begin
            if (cs_fall && eip) begin
                cmd_r <= FAST_READ_CMD; // R8
            end else if (byte_done && st_r == ST_CMD) begin
                cmd_r <= in_byte; // R7
            end
            if (byte_done && st_r == ST_ADDR) begin
                addr_r <= {addr_r[15:0], in_byte}; // R3 R20
                otp_ptr_r <= in_byte[OTP_AW-1:0];
            end else if (otp_adv) begin
                otp_ptr_r <= otp_ptr_r + 6'h01;
            end
            if (byte_done && st_r == ST_DIN) begin
                data_r <= in_byte;
            end
        end
    end

    // execute-in-place exit on confirmation bit of first dummy clock
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            exit_r <= 1'b0;
        end else if (cs_fall) begin
            exit_r <= 1'b0;
        end else if (sck_rise && st_r == ST_DUMMY && dcnt_r == dummy_ld && eip) begin
            exit_r <= i_lane_in[0]; // R8
        end
    end

    // output shifter, changes on falling clock
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur_r <= 8'h00;
            obit_r <= 3'h0;
            lane_out_r <= 4'h0;
            lane_oe_r <= 4'h0;
        end else if (cs_rise || cs_fall) begin
            obit_r <= 3'h0;
            lane_oe_r <= 4'h0; // R11
        end else if (sck_fall && st_r == ST_DOUT) begin
            cur_r <= nb;
            obit_r <= 3'(obit_r + lw[2:0]);
            lane_out_r <= lane_nxt; // R3 R6 R10
            lane_oe_r <= oe_nxt;
        end
    end

    // configuration and status
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vcr_r <= VOLATILE_CFG_RST;
            vecr_r <= ENHANCED_CFG_RST;
            nvcr_r <= NVCFG_RST;
            sr_r <= STATUS_RST;
            wel_r <= 1'b0;
            rej_r <= 1'b0;
        end else begin
            if (cs_rise && exit_r) begin
                vecr_r[EXEC_IN_PLACE_BIT] <= 1'b0; // R8
            end else if (exec && cmd_r == ENHANCED_CONFIG_WRITE_CMD) begin
                vecr_r <= data_r; // R2
            end else if (start_op && is_nvw) begin
                vecr_r[PROTO_LSB +: 2] <= data_r[PROTO_LSB +: 2]; // R2
            end
            if (exec && cmd_r == VOLATILE_CONFIG_WRITE_CMD) begin
                vcr_r <= data_r;
            end
            if (start_op && is_nvw) begin
                nvcr_r <= data_r;
            end
            if (start_op && is_srw) begin
                sr_r <= data_r;
            end
            if (exec && cmd_r == WRITE_ENABLE_CMD) begin
                wel_r <= 1'b1;
            end else if (start_op || (exec && cmd_r == WRITE_DISABLE_CMD)) begin
                wel_r <= 1'b0;
            end
            if (rej_set) begin
                rej_r <= 1'b1; // R12
            end else if (exec && cmd_r == FLAG_CLEAR_CMD) begin
                rej_r <= 1'b0;
            end
        end
    end

    // internal modify cycle tracking
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_r <= 1'b0;
            susp_r <= 1'b0;
            kind_r <= OPK_PAGE;
            op_addr_r <= 24'h000000;
        end else begin
            if (start_op) begin
                busy_r <= 1'b1;
                kind_r <= kind_nxt;
                op_addr_r <= op_addr_nxt; // R20
            end else if (do_res) begin
                busy_r <= 1'b1; // R16
                susp_r <= 1'b0;
            end else if (do_susp) begin
                busy_r <= 1'b0; // R15
                susp_r <= 1'b1;
            end else if (i_op_done) begin
                busy_r <= 1'b0; // R14
            end
        end
    end

    // user-side strobes
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_req_r <= 1'b0;
            wr_valid_r <= 1'b0;
            op_start_r <= 1'b0;
            suspend_r <= 1'b0;
            resume_r <= 1'b0;
        end else begin
            rd_req_r <= byte_done && st_r == ST_ADDR && abyte_r == LAST_ADDR_BYTE && is_arr_rd && !busy_r;
            wr_valid_r <= byte_done && st_r == ST_DIN && is_pp && wel_r;
            op_start_r <= start_op;
            suspend_r <= do_susp;
            resume_r <= do_res;
        end
    end

    sf_byte_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rd_fifo (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_clear(cs_rise || cs_fall),
        .i_in_valid(i_rd_valid),
        .o_in_ready(o_rd_ready),
        .i_in_data(i_rd_data),
        .o_out_valid(fifo_valid),
        .i_out_ready(pop),
        .o_out_data(fifo_data)
    );

    sf_otp_mem #(
        .AW(OTP_AW),
        .DW(BYTE_W)
    ) u_otp (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_we(otp_we),
        .i_waddr(otp_ptr_r),
        .i_wdata(in_byte),
        .i_raddr(otp_ptr_r),
        .o_rdata(otp_rdata)
    );

    assign o_lane_out = lane_out_r;
    assign o_lane_oe = lane_oe_r;
    assign o_rd_req = rd_req_r;
    assign o_rd_addr = addr_r;
    assign o_wr_valid = wr_valid_r;
    assign o_wr_data = data_r;
    assign o_op_start = op_start_r;
    assign o_op_kind = kind_r;
    assign o_op_addr = op_addr_r;
    assign o_suspend = suspend_r;
    assign o_resume = resume_r;
    assign o_busy = busy_r;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    a_deselect_quiet: assert property (cs_rise |=> o_lane_oe == 4'h0) // R11
        else $error("lanes still driven after deselect");
    a_busy_no_read: assert property (o_rd_req |-> !busy_r) // R13
        else $error("array read issued during internal cycle");
    a_op_on_boundary: assert property (o_op_start |-> clk_cnt_r == 3'h0 && $past(cs_rise)) // R12
        else $error("modify started off byte boundary");
    a_reject_flag: assert property (rej_set |=> rej_r && !o_op_start) // R12
        else $error("misaligned write not rejected");
    a_suspend_kind: assert property (o_suspend |-> susp_r && !busy_r && can_susp) // R15
        else $error("suspend of non-suspendable cycle");
    a_resume_source: assert property (o_resume |-> $past(susp_r, 2) && busy_r) // R16
        else $error("resume without prior suspend");
    a_busy_holds: assert property (busy_r && !i_op_done && !do_susp |=> busy_r) // R14 R18
        else $error("internal cycle ended without done or suspend");
    a_quad_lanes: assert property (o_lane_oe == 4'hF |-> is_quad || (ext && cmd_r == QUAD_OUT_READ_CMD)) // R6 R9
        else $error("four lanes driven outside quad output");
    a_eip_no_cmd: assert property (cs_fall && eip |=> st_r == ST_ADDR && cmd_r == FAST_READ_CMD) // R8
        else $error("execute-in-place frame expected an instruction");
    a_poll_in_busy: assert property (st_r == ST_DEC && busy_r && is_poll |=> st_r == ST_DOUT) // R17
        else $error("poll refused during internal cycle");

    c_array_read: cover property (o_rd_req ##[1:400] pop);
    c_program: cover property (o_wr_valid ##[1:400] o_op_start);
    c_suspend_resume: cover property (o_suspend ##[1:1000] o_resume);
    c_reject: cover property (rej_set);
endmodule // serial_flash_frontend
`default_nettype wire

/* logic/sf_byte_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module sf_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_clear,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;
    assign o_out_valid = (wp_r != rp_r) && !i_clear;
    assign o_in_ready = !i_clear && ((wp_r[AW-1:0] != rp_r[AW-1:0]) || (wp_r[AW] == rp_r[AW]));
    assign o_out_data = mem_r[rp_r[AW-1:0]];
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem_r[wp_r[AW-1:0]] <= i_in_data;
        end
    end
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
        end else if (i_clear) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_r + (AW+1)'(push);
            rp_r <= rp_r + (AW+1)'(pop);
        end
    end
endmodule // sf_byte_fifo
`default_nettype wire

/* logic/sf_otp_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module sf_otp_mem #(
    parameter int AW = 6,
    parameter int DW = 8
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem_r [2**AW];
    logic [2**AW-1:0] prog_r;
    // programming only clears bits, unwritten bytes read erased
    always_ff @(posedge i_mclk) begin
        if (i_we) begin
            mem_r[i_waddr] <= prog_r[i_waddr] ? (mem_r[i_waddr] & i_wdata) : i_wdata;
        end
    end
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prog_r <= '0;
            o_rdata <= '1;
        end else begin
            if (i_we) begin
                prog_r[i_waddr] <= 1'b1;
            end
            o_rdata <= prog_r[i_raddr] ? mem_r[i_raddr] : '1;
        end
    end
endmodule // sf_otp_mem
`default_nettype wire

/* logic/sf_pkg.sv */
package sf_pkg;
    // instruction codes
    localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] FLAG_STATUS_READ_CMD = 8'h70;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] FLAG_CLEAR_CMD = 8'h50;
    localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
    localparam logic [7:0] FAST_READ_CMD = 8'h0B;
    localparam logic [7:0] QUAD_OUT_READ_CMD = 8'h6B;
    localparam logic [7:0] OTP_READ_CMD = 8'h4B;
    localparam logic [7:0] OTP_PROGRAM_CMD = 8'h42;
    localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
    localparam logic [7:0] SUBSECTOR_ERASE_CMD = 8'h20;
    localparam logic [7:0] SECTOR_ERASE_CMD = 8'hD8;
    localparam logic [7:0] WHOLE_CHIP_ERASE_CMD = 8'hC7;
    localparam logic [7:0] SUSPEND_PROGRAM_ERASE_CMD = 8'h75;
    localparam logic [7:0] RESUME_PROGRAM_ERASE_CMD = 8'h7A;
    localparam logic [7:0] NONVOLATILE_CONFIG_WRITE_CMD = 8'hB1;
    localparam logic [7:0] VOLATILE_CONFIG_WRITE_CMD = 8'h81;
    localparam logic [7:0] ENHANCED_CONFIG_WRITE_CMD = 8'h61;
    // protocol field codes
    localparam logic [1:0] QUAD_LANE_PROTOCOL = 2'h1;
    localparam logic [1:0] DUAL_LANE_PROTOCOL = 2'h2;
    // field positions
    localparam int PROTO_LSB = 6;
    localparam int EXEC_IN_PLACE_BIT = 3;
    localparam int DUMMY_LSB = 4;
    localparam int SR_BUSY = 0;
    localparam int SR_WEL = 1;
    localparam int FS_SUSPENDED = 2;
    localparam int FS_REJECTED = 4;
    localparam int FS_READY = 7;
    // reset values
    localparam logic [7:0] NVCFG_RST = 8'hC0;
    localparam logic [7:0] ENHANCED_CFG_RST = 8'hC0;
    localparam logic [7:0] VOLATILE_CFG_RST = 8'h80;
    localparam logic [7:0] STATUS_RST = 8'h00;
    // array geometry
    localparam logic [23:0] SUBSECTOR_MASK = 24'hFFF000;
    localparam logic [23:0] SECTOR_MASK = 24'hFF0000;
    localparam logic [1:0] LAST_ADDR_BYTE = 2'h2;
    localparam int OTP_AW = 6;
    localparam int FIFO_DEPTH = 8;
    localparam int BYTE_W = 8;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_DEC = 3'b010,
        ST_ADDR = 3'b011,
        ST_DUMMY = 3'b100,
        ST_DOUT = 3'b101,
        ST_DIN = 3'b110,
        ST_IGN = 3'b111
    } st_t;
    typedef enum logic [2:0] {
        OPK_PAGE = 3'b000,
        OPK_SUBSECTOR = 3'b001,
        OPK_SECTOR = 3'b010,
        OPK_CHIP = 3'b011,
        OPK_OTP = 3'b100,
        OPK_STATUS = 3'b101,
        OPK_NVCFG = 3'b110
    } op_kind_t;
endpackage

/* tb/serial_flash_frontend_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_flash_frontend_bench import sf_pkg::*; ;
    logic mclk, rst_n, cs_n, sclk, rd_req, rd_valid, rd_ready, op_start, op_done, suspend, resume, busy;
    logic [3:0] lane_in, lane_out, lane_oe;
    logic [7:0] rd_data;
    logic [2:0] op_kind, kind_r;
    logic [23:0] rd_addr, op_addr, addr_r, req_addr_r;
    int num_errors = 0, samples_checked = 0, n_start = 0, n_susp = 0, n_res = 0, n_req = 0;

    serial_flash_frontend i_serial_flash_frontend (.i_mclk(mclk), .i_rst_n(rst_n), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_lane_in(lane_in), .o_lane_out(lane_out), .o_lane_oe(lane_oe),
        .o_rd_req(rd_req), .o_rd_addr(rd_addr), .i_rd_valid(rd_valid), .o_rd_ready(rd_ready),
        .i_rd_data(rd_data), .o_wr_valid(), .o_wr_data(), .o_op_start(op_start), .o_op_kind(op_kind),
        .o_op_addr(op_addr), .i_op_done(op_done), .o_suspend(suspend), .o_resume(resume), .o_busy(busy));
    sf_backend_model i_sf_backend_model (.i_mclk(mclk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_rd_req(rd_req),
        .i_rd_addr(rd_addr), .i_rd_ready(rd_ready), .i_busy(busy), .o_rd_valid(rd_valid),
        .o_rd_data(rd_data), .o_op_done(op_done));

    always @(posedge mclk) begin
        if (op_start === 1'b1) n_start <= n_start + 1;
        if (op_start === 1'b1) kind_r <= op_kind;
        if (op_start === 1'b1) addr_r <= op_addr;
        if (suspend === 1'b1) n_susp <= n_susp + 1;
        if (resume === 1'b1) n_res <= n_res + 1;
        if (rd_req === 1'b1) n_req <= n_req + 1;
        if (rd_req === 1'b1) req_addr_r <= rd_addr;
    end
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    function automatic logic [23:0] sub_base(input logic [23:0] a);
        return {a[23:12], 12'h000};
    endfunction
    function automatic logic [23:0] two_bytes(input logic [23:0] a);
        return {8'h00, a[7:0], a[7:0] + 8'h01};
    endfunction
    task automatic final_report();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // one serial bit; read lane sampled just before the rising edge
    task automatic bit_x(input logic b, output logic r);
        lane_in = {3'($urandom), b};
        ticks(6);
        r = lane_out[1];
        sclk = 1'b1;
        ticks(6);
        sclk = 1'b0;
    endtask
    // returns the last two bytes seen on the output lane while the queued bytes are sent
    task automatic frame(input logic [7:0] q[$], input int extra, output logic [15:0] rx);
        logic r;
        cs_n = 1'b0;
        ticks(2);
        foreach (q[k]) begin
            for (int i = 7; i >= 0; i--) begin
                bit_x(q[k][i], r);
                rx = {rx[14:0], r};
            end
        end
        repeat (extra) bit_x(1'b0, r);
        cs_n = 1'b1;
        ticks(6);
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 5000) begin
            ticks(1);
            k++;
        end
        if (k >= 5000) begin
            num_errors++;
            $display("FAIL %0t busy never cleared", $time);
            final_report();
        end
    endtask

    initial begin
        logic [15:0] v;
        logic [23:0] a;
        rst_n = 1'b0;
        cs_n = 1'b1;
        sclk = 1'b0;
        lane_in = 4'h0;
        void'($urandom(86));
        ticks(20);
        rst_n = 1'b1;
        ticks(4);
        frame('{STATUS_READ_CMD, 8'h00}, 0, v);
        chk(24'(v[7:0]), 24'h000000);
        frame('{STATUS_READ_CMD}, 3, v);
        chk(24'({v[2:0], lane_oe}), 24'h000000);
        $display("test idle status done");
        frame('{WRITE_ENABLE_CMD}, 1, v);
        frame('{STATUS_READ_CMD, 8'h00}, 0, v);
        chk(24'(v[SR_WEL]), 24'h000000);
        frame('{FLAG_STATUS_READ_CMD, 8'h00}, 0, v);
        chk(24'(v[FS_REJECTED]), 24'h000001);
        frame('{FLAG_CLEAR_CMD}, 0, v);
        frame('{FLAG_STATUS_READ_CMD, 8'h00}, 0, v);
        chk(24'(v[FS_REJECTED]), 24'h000000);
        $display("test unaligned end done");
        a = 24'($urandom);
        frame('{WRITE_ENABLE_CMD}, 0, v);
        frame('{STATUS_READ_CMD, 8'h00}, 0, v);
        chk(24'(v[SR_WEL]), 24'h000001);
        frame('{SUBSECTOR_ERASE_CMD, a[23:16], a[15:8], a[7:0]}, 0, v);
        chk(24'(n_start), 24'h000001);
        chk(24'(kind_r), 24'(OPK_SUBSECTOR));
        chk(addr_r, sub_base(a));
        frame('{ARRAY_READ_CMD, a[23:16], a[15:8], a[7:0], 8'h00}, 0, v);
        chk(24'(n_req), 24'h000000);
        frame('{STATUS_READ_CMD, 8'h00}, 0, v);
        chk(24'(v[SR_BUSY]), 24'h000001);
        frame('{SUSPEND_PROGRAM_ERASE_CMD}, 0, v);
        chk(24'({n_susp[0], busy}), 24'h000002);
        frame('{FLAG_STATUS_READ_CMD, 8'h00}, 0, v);
        chk(24'(v[FS_SUSPENDED]), 24'h000001);
        frame('{RESUME_PROGRAM_ERASE_CMD}, 0, v);
        chk(24'({n_res[0], busy}), 24'h000003);
        wait_idle();
        chk(24'(n_start), 24'h000001);
        $display("test erase suspend resume done");
        a = 24'($urandom);
        frame('{ARRAY_READ_CMD, a[23:16], a[15:8], a[7:0], 8'h00, 8'h00}, 0, v);
        chk(req_addr_r, a);
        chk(24'(v), two_bytes(a));
        $display("test array read done");
        frame('{WRITE_ENABLE_CMD}, 0, v);
        frame('{OTP_PROGRAM_CMD, 8'h00, 8'h00, 8'h05, a[7:0]}, 0, v);
        chk(24'(kind_r), 24'(OPK_OTP));
        wait_idle();
        frame('{OTP_READ_CMD, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00}, 0, v);
        chk(24'(v[7:0]), 24'(a[7:0]));
        $display("test otp done");
        final_report();
    end
endmodule // serial_flash_frontend_bench
`default_nettype wire

/* tb/sf_backend_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sf_backend_model #(
    parameter int DONE_DELAY = 2000
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic i_rd_req,
    input wire logic [23:0] i_rd_addr,
    input wire logic i_rd_ready,
    input wire logic i_busy,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data,
    output logic o_op_done
);
    logic [15:0] cnt_r;
    // array byte equals low address byte, counting up
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_valid <= 1'b0;
            o_rd_data <= 8'h00;
            o_op_done <= 1'b0;
            cnt_r <= 16'h0000;
        end else begin
            if (i_rd_req) begin
                o_rd_valid <= 1'b1;
                o_rd_data <= i_rd_addr[7:0];
            end else if (i_cs_n) begin
                o_rd_valid <= 1'b0;
                o_rd_data <= ~o_rd_data;
            end else if (o_rd_valid && i_rd_ready) begin
                o_rd_data <= o_rd_data + 8'h01;
            end
            cnt_r <= i_busy ? cnt_r + 16'h0001 : 16'h0000;
            o_op_done <= i_busy && (cnt_r == 16'(DONE_DELAY)) && !o_op_done;
        end
    end
endmodule // sf_backend_model
`default_nettype wire
